// file: tsi_pkg.sv
// Constants and types for the time slot interchange connection control
// What this block does
// R1 - Split bit: reads data memory, writes source memory
// R2 - Processor-output bit sends source words everywhere
// R3 - Select 01 data, 10 source, 11 control
// R4 - Stream field picks memory subsection for channels
// R5 - Control memory bits 7-3 read zero
// R6 - Source-select or processor-output sends source word
// R7 - Otherwise source word addresses the data memory
// R8 - External control bit leads transmit by one channel
// R9 - Output-enable bit gates channel driver
// R10 - Source word bits 7-5 pick input stream
// R11 - Source word bits 4-0 pick input channel
// R12 - Processor-output forces source-select and output-enable
// R13 - Address line five picks register or channels
// R14 - Drive enable pin low floats every output
// R15 - Channel 1 control bits sent during channel 0
// R16 - Received bytes stored by stream and channel
package tsi_pkg;
    // ------------------------------------------------------------------
    // Mode and select register layout
    // ------------------------------------------------------------------
    localparam int         MODE_SPLIT_BIT  = 7;
    localparam int         MODE_PROC_BIT   = 6;
    localparam int         MODE_MS_HI      = 4;
    localparam int         MODE_MS_LO      = 3;
    localparam int         MODE_STA_HI     = 2;
    localparam int         MODE_STA_LO     = 0;
    localparam logic [7:0] MODE_RESET      = 8'h00;
    localparam logic [7:0] MODE_USED_MASK  = 8'hDF;
    localparam int         ADDR_LINE_FIVE  = 5;

    // ------------------------------------------------------------------
    // Per-channel control and source word layout
    // ------------------------------------------------------------------
    localparam int         CTL_SRC_BIT     = 2;
    localparam int         CTL_EXT_BIT     = 1;
    localparam int         CTL_OE_BIT      = 0;
    localparam logic [2:0] CTL_RESET       = 3'h0;
    localparam int         SRC_STREAM_HI   = 7;
    localparam int         SRC_STREAM_LO   = 5;
    localparam int         SRC_CHAN_HI     = 4;
    localparam int         SRC_CHAN_LO     = 0;

    // ------------------------------------------------------------------
    // Sizes and buffer
    // ------------------------------------------------------------------
    localparam int         NUM_POS         = 256;
    localparam logic [7:0] LAST_POS        = 8'hFF;
    localparam logic [7:0] CHAN_AHEAD      = 8'h08;
    localparam logic [1:0] BUF_DEPTH       = 2'h2;

    // Memory select codes
    typedef enum logic [1:0] {
        TSI_MS_NONE = 2'b00,
        TSI_MS_DATA = 2'b01,
        TSI_MS_SRC  = 2'b10,
        TSI_MS_CTL  = 2'b11
    } tsi_ms_t;

    // Memory index from stream and channel
    function automatic logic [7:0] tsi_index(input logic [2:0] stream,
                                             input logic [4:0] chan);
        return {stream, chan};
    endfunction : tsi_index
endpackage : tsi_pkg

// file: tsi_conn_ctrl.sv
// Connection control and per-channel memories of the slot interchange
`timescale 1ns/1ps
module tsi_conn_ctrl
    import tsi_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       srst,
    // Processor port
    input  wire logic       cpu_sel,
    input  wire logic       cpu_write,
    input  wire logic [5:0] cpu_addr,
    input  wire logic [7:0] cpu_wdata,
    output logic      [7:0] cpu_rdata,
    output logic            cpu_ack,
    // Receive side, one parallel byte per input channel
    input  wire logic       rx_valid,
    input  wire logic [2:0] rx_stream,
    input  wire logic [4:0] rx_chan,
    input  wire logic [7:0] rx_byte,
    // Frame timing and master drive control
    input  wire logic       frame_pulse,
    input  wire logic       output_drive_enable_pin,
    // Transmit side towards the serialisers
    output logic            tx_valid,
    input  wire logic       tx_ready,
    output logic      [2:0] tx_stream,
    output logic      [4:0] tx_chan,
    output logic      [7:0] tx_byte,
    output logic            tx_drive,
    output logic            external_control_bit
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0] switch_mode_select;
    logic [7:0] data_mem [NUM_POS];
    logic [7:0] per_channel_source_memory [NUM_POS];
    logic [2:0] per_channel_control_memory [NUM_POS];

    // Decoded mode fields
    logic       memory_split;
    logic       processor_output;
    tsi_ms_t    memory_select_field;
    logic [2:0] stream_address_field;
    logic       chan_access;
    logic [7:0] cpu_idx;

    assign memory_split         = switch_mode_select[MODE_SPLIT_BIT];
    assign processor_output     = switch_mode_select[MODE_PROC_BIT];
    assign memory_select_field  =
        tsi_ms_t'(switch_mode_select[MODE_MS_HI:MODE_MS_LO]);
    assign stream_address_field =
        switch_mode_select[MODE_STA_HI:MODE_STA_LO];
    assign chan_access = cpu_addr[ADDR_LINE_FIVE];                   // R13
    assign cpu_idx = tsi_index(stream_address_field, cpu_addr[4:0]); // R4

    // ------------------------------------------------------------------
    // Processor writes
    // ------------------------------------------------------------------
    logic wr_src;
    logic wr_ctl;

    // Split mode steers every channel write to the source memory
    assign wr_src = cpu_sel && cpu_write && chan_access &&
                    (memory_split ||                               // R1
                     memory_select_field == TSI_MS_SRC);           // R3
    assign wr_ctl = cpu_sel && cpu_write && chan_access &&
                    !memory_split &&
                    memory_select_field == TSI_MS_CTL;             // R3

    // Mode register; unused bit 5 is never stored
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            switch_mode_select <= MODE_RESET;
        end else if (cpu_sel && cpu_write && !chan_access) begin   // R13
            switch_mode_select <= cpu_wdata & MODE_USED_MASK;
        end
    end

    // Source memory holds no reset: software programs it before use
    always_ff @(posedge sys_clk) begin
        if (wr_src) begin
            per_channel_source_memory[cpu_idx] <= cpu_wdata;
        end
    end

    // Control memory cleared at reset so no channel drives unprogrammed
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < NUM_POS; i++) begin
                per_channel_control_memory[i] <= CTL_RESET;
            end
        end else if (wr_ctl) begin
            per_channel_control_memory[cpu_idx] <= cpu_wdata[2:0];
        end
    end

    // Receive bytes land by stream and channel; data memory is read only
    // from the processor side, so this is its only writer
    always_ff @(posedge sys_clk) begin
        if (rx_valid) begin
            data_mem[tsi_index(rx_stream, rx_chan)] <= rx_byte;    // R16
        end
    end

    // ------------------------------------------------------------------
    // Processor reads, answered one cycle after the request
    // ------------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (!chan_access) begin
            next_rdata = switch_mode_select;
        end else if (memory_split) begin
            next_rdata = data_mem[cpu_idx];                        // R1
        end else begin
            unique case (memory_select_field)
                TSI_MS_DATA: next_rdata = data_mem[cpu_idx];       // R3
                TSI_MS_SRC:  next_rdata = per_channel_source_memory[cpu_idx];
                TSI_MS_CTL:  next_rdata = {5'h00,                  // R5
                                 per_channel_control_memory[cpu_idx]};
                TSI_MS_NONE: next_rdata = 8'h00;   // Forbidden code reads 0
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cpu_rdata <= 8'h00;
            cpu_ack   <= 1'b0;
        end else begin
            cpu_ack <= cpu_sel;
            if (cpu_sel && !cpu_write) begin
                cpu_rdata <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit generator: walks channel-major, stream-minor so that the
    // external control bits of one channel go out in stream order
    // ------------------------------------------------------------------
    logic [7:0] pos;
    logic       gen_run;
    logic       gen_valid;
    logic       gen_ready;
    logic [2:0] g_stream;
    logic [4:0] g_chan;
    logic [7:0] g_idx;
    logic [7:0] g_ahead;
    logic [2:0] g_ctl;
    logic [7:0] g_src;
    logic       g_use_src;
    logic       g_oe;
    logic [7:0] g_byte;
    logic [17:0] g_word;

    assign g_stream  = pos[2:0];
    assign g_chan    = pos[7:3];
    assign g_idx     = tsi_index(g_stream, g_chan);
    assign g_ahead   = pos + CHAN_AHEAD;                    // R8 R15
    assign g_ctl     = per_channel_control_memory[g_idx];
    assign g_src     = per_channel_source_memory[g_idx];
    assign g_use_src = g_ctl[CTL_SRC_BIT] || processor_output;   // R6 R12
    assign g_oe      = g_ctl[CTL_OE_BIT] || processor_output;    // R9 R12
    assign g_byte    = g_use_src ? g_src :                       // R2 R6
        data_mem[tsi_index(g_src[SRC_STREAM_HI:SRC_STREAM_LO],  // R7 R10
                           g_src[SRC_CHAN_HI:SRC_CHAN_LO])];    // R11
    assign gen_valid = gen_run;
    assign g_word    = {g_stream, g_chan, g_byte,
                        g_oe && output_drive_enable_pin,         // R9 R14
                        per_channel_control_memory[
                            tsi_index(g_ahead[2:0],
                                      g_ahead[7:3])][CTL_EXT_BIT]}; // R8

    // Stalls while the buffer is full; the frame pulse restarts a walk
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pos     <= 8'h00;
            gen_run <= 1'b0;
        end else if (frame_pulse) begin
            pos     <= 8'h00;
            gen_run <= 1'b1;
        end else if (gen_valid && gen_ready) begin
            pos <= pos + 8'h01;
            if (pos == LAST_POS) begin
                gen_run <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Two-entry buffer; head entry drives the transmit ports directly
    // ------------------------------------------------------------------
    logic [17:0] head;
    logic [17:0] tail;
    logic [1:0]  count;
    logic        push;
    logic        pop;

    assign gen_ready = count != BUF_DEPTH;
    assign push      = gen_valid && gen_ready;
    assign pop       = tx_valid && tx_ready;

    // Drive bits are wiped while the pin is low so stale words float too
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            head     <= 18'h00000;
            tail     <= 18'h00000;
            count    <= 2'h0;
            tx_valid <= 1'b0;
        end else begin
            if (count == 2'h0 || (count == 2'h1 && pop)) begin
                if (push) begin
                    head <= g_word;
                end
            end else if (count == 2'h1 && push) begin
                tail <= g_word;
            end else if (count == BUF_DEPTH && pop) begin
                head <= tail;
            end
            count    <= count + {1'b0, push} - {1'b0, pop};
            tx_valid <= (count + {1'b0, push} - {1'b0, pop}) != 2'h0;
            if (!output_drive_enable_pin) begin                    // R14
                head[1] <= 1'b0;
                tail[1] <= 1'b0;
            end
        end
    end

    assign tx_stream            = head[17:15];
    assign tx_chan              = head[14:10];
    assign tx_byte              = head[9:2];
    assign tx_drive             = head[1];
    assign external_control_bit = head[0];

endmodule : tsi_conn_ctrl

// file: tsi_conn_ctrl_properties.sv
// Port-level assertions for the connection control block
`timescale 1ns/1ps
module tsi_conn_ctrl_properties
    import tsi_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       srst,
    // Processor port
    input wire logic       cpu_sel,
    input wire logic       cpu_write,
    input wire logic [5:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic [7:0] cpu_rdata,
    input wire logic       cpu_ack,
    // Transmit side
    input wire logic       frame_pulse,
    input wire logic       output_drive_enable_pin,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic [2:0] tx_stream,
    input wire logic [4:0] tx_chan,
    input wire logic [7:0] tx_byte,
    input wire logic       tx_drive
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic [7:0] mode;
    logic       rd;
    assign rd = cpu_sel && !cpu_write;
    // Shadow of the mode register, so reads can be predicted
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode <= MODE_RESET;
        end else if (cpu_sel && cpu_write && !cpu_addr[ADDR_LINE_FIVE]) begin
            mode <= cpu_wdata;
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_ack_follows_sel: assert property (cpu_sel |=> cpu_ack)
        else $error("access without acknowledge");
    a_ack_needs_sel: assert property (!cpu_sel |=> !cpu_ack)
        else $error("acknowledge without access");
    a_mode_read_back: assert property (rd && !cpu_addr[ADDR_LINE_FIVE]
        |=> cpu_rdata == (mode & MODE_USED_MASK))
        else $error("mode read differs from last write");
    a_ctl_high_zero: assert property (rd && cpu_addr[ADDR_LINE_FIVE] &&
        mode[4:3] == TSI_MS_CTL && !mode[7] |=> cpu_rdata[7:3] == 5'h00)
        else $error("control read has upper bits set");
    a_none_reads_zero: assert property (rd && cpu_addr[ADDR_LINE_FIVE] &&
        mode[4:3] == TSI_MS_NONE && !mode[7] |=> cpu_rdata == 8'h00)
        else $error("unused select read not zero");
    a_rdata_holds: assert property (!rd |=> $stable(cpu_rdata))
        else $error("read data moved without a read");
    a_stall_holds: assert property (tx_valid && !tx_ready |=> tx_valid &&
        $stable({tx_stream, tx_chan, tx_byte}))
        else $error("stalled word changed");
    a_pin_floats: assert property (!output_drive_enable_pin &&
        !$past(output_drive_enable_pin) && tx_valid |-> !tx_drive)
        else $error("driver on while drive pin low");
    a_first_word: assert property (!tx_valid ##1 (!tx_valid && frame_pulse)
        |-> ##2 tx_valid && tx_chan == 5'h00 && tx_stream == 3'h0)
        else $error("frame does not start at position zero");
    c_stall: cover property (tx_valid && !tx_ready);
    c_split_read: cover property (rd && mode[7]);
    c_proc_mode: cover property (mode[6] && tx_valid && tx_drive);
endmodule : tsi_conn_ctrl_properties

bind tsi_conn_ctrl tsi_conn_ctrl_properties i_props (.*);

// file: tsi_tx_sink.sv
// Transmit consumer model that stalls the block at random
`timescale 1ns/1ps
module tsi_tx_sink (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic srst,
    // Handshake
    output logic      tx_ready
);
    logic [7:0] lfsr;
    // Random ready fills the two-entry buffer; it empties only between frames
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lfsr     <= 8'h5A;
            tx_ready <= 1'b0;
        end else begin
            lfsr     <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            tx_ready <= lfsr[0] | lfsr[1];
        end
    end
endmodule : tsi_tx_sink

// file: tsi_connection_control_test.sv
// Self-checking bench for the connection control block
`timescale 1ns/1ps
module tsi_connection_control_test
    import tsi_pkg::*;
;
    logic        sys_clk = 1'b0, srst = 1'b1, cpu_sel = 1'b0, cpu_write = 1'b0;
    logic        rx_valid = 1'b0, frame_pulse = 1'b0;
    logic        output_drive_enable_pin = 1'b0;
    logic [5:0]  cpu_addr = 6'h00;
    logic [7:0]  cpu_wdata = 8'h00, rx_byte = 8'h00, lf = 8'h32;
    logic [2:0]  rx_stream = 3'h0, tx_stream;
    logic [4:0]  rx_chan = 5'h00, tx_chan;
    logic [7:0]  cpu_rdata, tx_byte;
    logic        cpu_ack, tx_valid, tx_ready, tx_drive, external_control_bit;
    logic [7:0]  ctl_m [256], src_m [256], dat_m [256];
    logic [7:0]  rd_q [$];
    logic [17:0] tx_q [$];
    int          mismatches = 0, n_tests = 0;
    // Access kind seen at the previous edge, so only reads are compared
    logic        was_sel = 1'b0, was_rd = 1'b0;

    tsi_conn_ctrl i_dut (.*);
    tsi_tx_sink   i_sink (.*);
    // Free-running 50 MHz clock
    always #10 sys_clk = ~sys_clk;

    function automatic logic [7:0] rnd();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction : rnd
    // Expected word for walk position p: stream is p[2:0], channel p[7:3]
    function automatic logic [17:0] exp_tx(input logic pe, input logic pin,
                                           input logic [7:0] p);
        logic [7:0] m;
        logic [7:0] w;
        m = {p[2:0], p[7:3]};
        w = src_m[m];
        return {m[7:5], m[4:0], (pe | ctl_m[m][2]) ? w : dat_m[w],
                pin & (pe | ctl_m[m][0]), ctl_m[{m[7:5], m[4:0] + 5'h01}][1]};
    endfunction : exp_tx

    task automatic tally_and_finish();
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cmp_rd(input logic [7:0] got);
        n_tests++;
        if (rd_q.size() == 0 || rd_q[0] !== got) begin
            mismatches++;
            $display("wrong value %0t read data %h", $time, got);
        end
        if (rd_q.size() != 0) void'(rd_q.pop_front());
    endtask : cmp_rd
    task automatic cmp_ack(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %0t acknowledge %b", $time, got);
        end
    endtask : cmp_ack
    task automatic cmp_tx(input logic [17:0] got);
        n_tests++;
        if (tx_q.size() == 0 || tx_q[0] !== got) begin
            mismatches++;
            $display("wrong value %0t transmit word %h", $time, got);
        end
        if (tx_q.size() != 0) void'(tx_q.pop_front());
    endtask : cmp_tx
    // One strobe access; a free cycle always follows the strobe
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cpu_sel   <= 1'b1;
        cpu_write <= w;
        cpu_addr  <= a;
        cpu_wdata <= d;
        @(posedge sys_clk);
        cpu_sel   <= 1'b0;
    endtask : bus
    // Select memory and stream, then reach the channel; reads note d
    task automatic acc(input logic [4:0] hi, input logic w,
                       input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, {1'b0, idx[4:0]}, {hi, idx[7:5]});
        if (!w) rd_q.push_back(d);
        bus(w, {1'b1, idx[4:0]}, d);
    endtask : acc

    // Result watcher: oldest note against each read answer; write
    // acknowledges carry no data and leave the read queue alone
    always @(posedge sys_clk) begin
        if (!srst) cmp_ack(cpu_ack, was_sel);
        if (!srst && cpu_ack === 1'b1 && was_rd) cmp_rd(cpu_rdata);
        if (!srst && tx_valid === 1'b1 && tx_ready === 1'b1)
            cmp_tx({tx_stream, tx_chan, tx_byte, tx_drive,
                    external_control_bit});
        was_sel = cpu_sel;
        was_rd  = cpu_sel && !cpu_write;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] w, c;
        int         k, t;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        rd_q.push_back(8'h00);
        bus(1'b0, 6'h25, 8'h00);
        rd_q.push_back(8'h00);
        bus(1'b0, 6'h0A, 8'h00);
        acc(5'h03, 1'b0, 8'h00, 8'h00);
        bus(1'b1, 6'h11, 8'hFF);
        rd_q.push_back(8'hDF);
        bus(1'b0, 6'h1E, 8'h00);
        for (k = 0; k < 256; k++) begin
            ctl_m[k] = rnd() & 8'h07;
            src_m[k] = rnd();
            acc(5'h03, 1'b1, 8'(k), ctl_m[k]);
            acc(5'h02, 1'b1, 8'(k), src_m[k]);
        end
        // Receive one byte per position into the data memory
        for (k = 0; k < 256; k++) begin
            @(posedge sys_clk);
            dat_m[k] = rnd();
            {rx_stream, rx_chan} <= 8'(k);
            rx_byte  <= dat_m[k];
            rx_valid <= 1'b1;
        end
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        for (k = 0; k < 8; k++) begin
            c = 8'(k * 36);
            acc(5'h03, 1'b0, c, ctl_m[c]);
            acc(5'h02, 1'b0, c, src_m[c]);
            acc(5'h01, 1'b1, c, 8'hA5);
            acc(5'h01, 1'b0, c, dat_m[c]);
            acc(5'h12, 1'b0, c, dat_m[c]);
            w = rnd();
            acc(5'h12, 1'b1, c, w);
            src_m[c] = w;
            acc(5'h02, 1'b0, c, w);
        end
        // Three frames: normal, processor output, drive pin low
        for (k = 0; k < 3; k++) begin
            output_drive_enable_pin <= (k != 2);
            bus(1'b1, 6'h00, (k == 1) ? 8'h50 : 8'h10);
            for (t = 0; t < 256; t++)
                tx_q.push_back(exp_tx(k == 1, k != 2, 8'(t)));
            @(posedge sys_clk);
            frame_pulse <= 1'b1;
            @(posedge sys_clk);
            frame_pulse <= 1'b0;
            for (t = 0; t < 5000 && tx_q.size() != 0; t++) @(posedge sys_clk);
            if (tx_q.size() != 0) begin
                mismatches++;
                tally_and_finish();
            end
        end
        repeat (4) @(posedge sys_clk);
        if (rd_q.size() != 0) mismatches++;
        tally_and_finish();
    end
endmodule : tsi_connection_control_test
